// >>> src/scan_tap_top.sv
// Full-scan test mode control and boundary-scan test access port.
//
// Operation
// - Full-scan mode input low enables the ten internal scan chains.
// - Scan chain flip-flops are clocked by the primary bus clock.
// - Full-scan active and select low: chains shift serially each rising edge.
// - Full-scan active and select high: chains capture in parallel.
// - The test clock times all state and data of the TAP.
// - The controller steers TAP states by TMS; device follows TMS.
// - With select high, data and instructions shift in from TDI.
// - With select high, data shifts out on TDO.
// - A low test reset forces the TAP into its reset state.
`default_nettype none
module scan_tap_top #(
   // Arbitrary neutral identification value.
   parameter logic [31:0] ID_VALUE = 32'h0000_0001
) (
   input  wire logic       i_clock,
   input  wire logic       i_sys_rst,
   input  wire logic       i_full_scan_mode_n,
   input  wire logic       i_scan_select,
   input  wire logic [7:0] i_sec1_request_pin,
   input  wire logic [6:0] i_sec2_request_pin_n,
   input  wire logic [7:0] i_func_sec1_grant_n,
   input  wire logic [6:0] i_func_sec2_grant_n,
   input  wire logic [79:0] i_capture_data,
   output logic      [7:0] o_sec1_grant_pin_n,
   output logic      [6:0] o_sec2_grant_pin_n,
   output logic      [7:0] o_func_sec1_request,
   output logic      [6:0] o_func_sec2_request_n,
   output logic            o_full_scan_active,
   input  wire logic       i_tck,
   input  wire logic       i_tms,
   input  wire logic       i_tdi,
   input  wire logic       i_trst_n,
   output logic            o_tdo,
   output logic            o_tdo_oe
);

   localparam int unsigned NC = scan_tap_pkg::NUM_CHAINS;
   localparam int unsigned LO = scan_tap_pkg::SCAN_LSB;
   localparam int unsigned HALF = NC / 2;

   // ----------------------------------------------------------------
   // Pin synchronisers in the bus clock domain
   // ----------------------------------------------------------------
   logic       mode_n_s;
   logic       select_s;
   logic [7:0] req1_s;
   logic [6:0] req2_s;

   pin_sync #(
      .WIDTH (2),
      .INIT  (2'h1)
   ) u_mode_sync (
      .i_clock (i_clock),
      .i_rst   (i_sys_rst),
      .i_async ({i_scan_select, i_full_scan_mode_n}),
      .o_sync  ({select_s, mode_n_s})
   );

   pin_sync #(
      .WIDTH (15),
      .INIT  ({scan_tap_pkg::SEC2_IDLE, scan_tap_pkg::SEC1_IDLE})
   ) u_req_sync (
      .i_clock (i_clock),
      .i_rst   (i_sys_rst),
      .i_async ({i_sec2_request_pin_n, i_sec1_request_pin}),
      .o_sync  ({req2_s, req1_s})
   );

   // ----------------------------------------------------------------
   // Full-scan chains
   // ----------------------------------------------------------------
   logic          scan_on;
   logic [NC-1:0] chain_in;
   logic [NC-1:0] chain_out;

   assign scan_on = ~mode_n_s;
   assign chain_in = {req2_s[LO +: HALF], req1_s[LO +: HALF]};

   scan_chain_bank #(
      .CHAINS (NC),
      .LEN    (scan_tap_pkg::CHAIN_LEN)
   ) u_chains (
      .i_clock        (i_clock),
      .i_rst          (i_sys_rst),
      .i_enable       (scan_on),
      .i_capture      (select_s),
      .i_scan_in      (chain_in),
      .i_capture_data (i_capture_data),
      .o_scan_out     (chain_out)
   );

   // ----------------------------------------------------------------
   // Grant and request pin ownership
   // ----------------------------------------------------------------
   // The pins are registered after the mux so a mode change never
   // produces a combinational glitch on a grant line.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_sec1_grant_pin_n <= scan_tap_pkg::SEC1_IDLE;
         o_sec2_grant_pin_n <= scan_tap_pkg::SEC2_IDLE;
      end else if (scan_on) begin
         o_sec1_grant_pin_n <= i_func_sec1_grant_n;
         o_sec2_grant_pin_n <= i_func_sec2_grant_n;
         o_sec1_grant_pin_n[LO +: HALF] <= chain_out[HALF-1:0];
         o_sec2_grant_pin_n[LO +: HALF] <= chain_out[NC-1:HALF];
      end else begin
         o_sec1_grant_pin_n <= i_func_sec1_grant_n;
         o_sec2_grant_pin_n <= i_func_sec2_grant_n;
      end
   end

   // While scanning, requests to the arbiter read as idle so scan
   // patterns cannot start bus cycles.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_func_sec1_request   <= scan_tap_pkg::SEC1_IDLE;
         o_func_sec2_request_n <= scan_tap_pkg::SEC2_IDLE;
      end else if (scan_on) begin
         o_func_sec1_request   <= scan_tap_pkg::SEC1_IDLE;
         o_func_sec2_request_n <= scan_tap_pkg::SEC2_IDLE;
      end else begin
         o_func_sec1_request   <= req1_s;
         o_func_sec2_request_n <= req2_s;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_full_scan_active <= 1'b0;
      end else begin
         o_full_scan_active <= scan_on;
      end
   end

   // ----------------------------------------------------------------
   // Crossing into the test clock domain
   // ----------------------------------------------------------------
   // Status bits are quasi-static, so each passes two flip-flops alone;
   // a word read mid-change may mix old and new bits, harmless here.
   logic [3:0] stat_src;
   logic [3:0] stat_m_r;
   logic [3:0] stat_t_r;
   logic       tsel_m_r;
   logic       tsel_2_r;
   logic       tsel_3_r;
   logic       tsel_r;

   assign stat_src = {chain_out[0], select_s, scan_on, mode_n_s};
   always_ff @(posedge i_tck or negedge i_trst_n) begin
      if (!i_trst_n) begin
         stat_m_r <= 4'h0;
         stat_t_r <= 4'h0;
      end else begin
         stat_m_r <= stat_src;
         stat_t_r <= stat_m_r;
      end
   end

   // The select pin reaches the TAP through its own three stages.
   always_ff @(posedge i_tck or negedge i_trst_n) begin
      if (!i_trst_n) begin
         tsel_m_r <= 1'b0;
         tsel_2_r <= 1'b0;
         tsel_3_r <= 1'b0;
         tsel_r   <= 1'b0;
      end else begin
         tsel_m_r <= i_scan_select;
         tsel_2_r <= tsel_m_r;
         tsel_3_r <= tsel_2_r;
         if (tsel_2_r == tsel_3_r) begin
            tsel_r <= tsel_3_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // TAP state machine
   // ----------------------------------------------------------------
   scan_tap_pkg::tap_state_t state_r;
   scan_tap_pkg::tap_state_t state_nxt;
   always_comb begin
      unique case (state_r)
         scan_tap_pkg::TAP_RESET:
            state_nxt = i_tms ? scan_tap_pkg::TAP_RESET
                              : scan_tap_pkg::TAP_IDLE;
         scan_tap_pkg::TAP_IDLE:
            state_nxt = i_tms ? scan_tap_pkg::TAP_SEL_DR
                              : scan_tap_pkg::TAP_IDLE;
         scan_tap_pkg::TAP_SEL_DR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_SEL_IR
                              : scan_tap_pkg::TAP_CAP_DR;
         scan_tap_pkg::TAP_CAP_DR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_EX1_DR
                              : scan_tap_pkg::TAP_SH_DR;
         scan_tap_pkg::TAP_SH_DR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_EX1_DR
                              : scan_tap_pkg::TAP_SH_DR;
         scan_tap_pkg::TAP_EX1_DR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_UPD_DR
                              : scan_tap_pkg::TAP_PAU_DR;
         scan_tap_pkg::TAP_PAU_DR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_EX2_DR
                              : scan_tap_pkg::TAP_PAU_DR;
         scan_tap_pkg::TAP_EX2_DR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_UPD_DR
                              : scan_tap_pkg::TAP_SH_DR;
         scan_tap_pkg::TAP_UPD_DR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_SEL_DR
                              : scan_tap_pkg::TAP_IDLE;
         scan_tap_pkg::TAP_SEL_IR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_RESET
                              : scan_tap_pkg::TAP_CAP_IR;
         scan_tap_pkg::TAP_CAP_IR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_EX1_IR
                              : scan_tap_pkg::TAP_SH_IR;
         scan_tap_pkg::TAP_SH_IR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_EX1_IR
                              : scan_tap_pkg::TAP_SH_IR;
         scan_tap_pkg::TAP_EX1_IR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_UPD_IR
                              : scan_tap_pkg::TAP_PAU_IR;
         scan_tap_pkg::TAP_PAU_IR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_EX2_IR
                              : scan_tap_pkg::TAP_PAU_IR;
         scan_tap_pkg::TAP_EX2_IR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_UPD_IR
                              : scan_tap_pkg::TAP_SH_IR;
         scan_tap_pkg::TAP_UPD_IR:
            state_nxt = i_tms ? scan_tap_pkg::TAP_SEL_DR
                              : scan_tap_pkg::TAP_IDLE;
      endcase
   end

   always_ff @(posedge i_tck or negedge i_trst_n) begin
      if (!i_trst_n) begin
         state_r <= scan_tap_pkg::TAP_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Instruction and data registers
   // ----------------------------------------------------------------
   logic [3:0]  ir_sh_r;
   logic [3:0]  ir_r;
   logic        byp_r;
   logic [31:0] id_sh_r;
   logic [7:0]  st_sh_r;
   logic        shift_ok;
   assign shift_ok = tsel_r;
   always_ff @(posedge i_tck or negedge i_trst_n) begin
      if (!i_trst_n) begin
         ir_sh_r <= scan_tap_pkg::IR_RESET;
         ir_r    <= scan_tap_pkg::IR_RESET;
      end else begin
         unique case (state_r)
            scan_tap_pkg::TAP_RESET:  ir_r    <= scan_tap_pkg::IR_RESET;
            scan_tap_pkg::TAP_CAP_IR: ir_sh_r <= scan_tap_pkg::IR_CAPTURE;
            scan_tap_pkg::TAP_SH_IR: begin
               if (shift_ok) begin
                  ir_sh_r <= {i_tdi, ir_sh_r[3:1]};
               end
            end
            scan_tap_pkg::TAP_UPD_IR: ir_r    <= ir_sh_r;
            default:                  ir_r    <= ir_r;
         endcase
      end
   end

   always_ff @(posedge i_tck or negedge i_trst_n) begin
      if (!i_trst_n) begin
         byp_r   <= 1'b0;
         id_sh_r <= 32'h0000_0000;
         st_sh_r <= 8'h00;
      end else if (state_r == scan_tap_pkg::TAP_CAP_DR) begin
         byp_r   <= 1'b0;
         id_sh_r <= ID_VALUE;
         st_sh_r <= {4'h0, stat_t_r};
      end else if (state_r == scan_tap_pkg::TAP_SH_DR && shift_ok) begin
         byp_r   <= i_tdi;
         id_sh_r <= {i_tdi, id_sh_r[31:1]};
         st_sh_r <= {i_tdi, st_sh_r[7:1]};
      end
   end

   // ----------------------------------------------------------------
   // Serial output at the falling test clock edge
   // ----------------------------------------------------------------
   logic dr_bit;
   always_comb begin
      unique case (ir_r)
         scan_tap_pkg::IR_IDCODE: dr_bit = id_sh_r[0];
         scan_tap_pkg::IR_STATUS: dr_bit = st_sh_r[0];
         default:                 dr_bit = byp_r;
      endcase
   end

   // Driving at the falling edge gives the controller half a period
   // of setup before it samples at the next rising edge.
   always_ff @(negedge i_tck or negedge i_trst_n) begin
      if (!i_trst_n) begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else if (shift_ok && state_r == scan_tap_pkg::TAP_SH_IR) begin
         o_tdo    <= ir_sh_r[0];
         o_tdo_oe <= 1'b1;
      end else if (shift_ok && state_r == scan_tap_pkg::TAP_SH_DR) begin
         o_tdo    <= dr_bit;
         o_tdo_oe <= 1'b1;
      end else begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// >>> src/scan_tap_pkg.sv
// Shared constants and types for the full-scan and test access port logic.
`default_nettype none
package scan_tap_pkg;

   // ----------------------------------------------------------------
   // Full-scan chains
   // ----------------------------------------------------------------
   localparam int unsigned NUM_CHAINS = 10;
   localparam int unsigned CHAIN_LEN  = 8;
   localparam int unsigned SCAN_LSB   = 2;

   // ----------------------------------------------------------------
   // Pins and reset values
   // ----------------------------------------------------------------
   localparam int unsigned SEC1_PINS = 8;
   localparam int unsigned SEC2_PINS = 7;
   localparam logic [7:0]  SEC1_IDLE = 8'hFF;
   localparam logic [6:0]  SEC2_IDLE = 7'h7F;

   // ----------------------------------------------------------------
   // Test access port
   // ----------------------------------------------------------------
   localparam int unsigned IR_LEN      = 4;
   localparam int unsigned ID_LEN      = 32;
   localparam int unsigned STAT_LEN    = 8;
   localparam logic [3:0]  IR_BYPASS   = 4'hF;
   localparam logic [3:0]  IR_IDCODE   = 4'h1;
   localparam logic [3:0]  IR_STATUS   = 4'h2;
   localparam logic [3:0]  IR_CAPTURE  = 4'h1;
   localparam logic [3:0]  IR_RESET    = 4'h1;

   typedef enum logic [3:0] {
      TAP_RESET   = 4'hF,
      TAP_IDLE    = 4'hC,
      TAP_SEL_DR  = 4'h7,
      TAP_CAP_DR  = 4'h6,
      TAP_SH_DR   = 4'h2,
      TAP_EX1_DR  = 4'h1,
      TAP_PAU_DR  = 4'h3,
      TAP_EX2_DR  = 4'h0,
      TAP_UPD_DR  = 4'h5,
      TAP_SEL_IR  = 4'h4,
      TAP_CAP_IR  = 4'hE,
      TAP_SH_IR   = 4'hA,
      TAP_EX1_IR  = 4'h9,
      TAP_PAU_IR  = 4'hB,
      TAP_EX2_IR  = 4'h8,
      TAP_UPD_IR  = 4'hD
   } tap_state_t;

endpackage
`default_nettype wire

// >>> src/pin_sync.sv
// Three-stage input synchroniser that accepts a change once stages agree.
`default_nettype none
module pin_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             i_clock,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // The first stage feeds only the second; filtering looks at 2 and 3.
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               meta_r[b] <= INIT[b];
               s2_r[b]   <= INIT[b];
               s3_r[b]   <= INIT[b];
               o_sync[b] <= INIT[b];
            end else begin
               meta_r[b] <= i_async[b];
               s2_r[b]   <= meta_r[b];
               s3_r[b]   <= s2_r[b];
               if (s2_r[b] == s3_r[b]) begin
                  o_sync[b] <= s3_r[b];
               end
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// >>> src/scan_chain_bank.sv
// Bank of parallel scan chains with shift and capture operation.
`default_nettype none
module scan_chain_bank #(
   parameter int unsigned CHAINS = scan_tap_pkg::NUM_CHAINS,
   parameter int unsigned LEN    = scan_tap_pkg::CHAIN_LEN
) (
   input  wire logic                  i_clock,
   input  wire logic                  i_rst,
   input  wire logic                  i_enable,
   input  wire logic                  i_capture,
   input  wire logic [CHAINS-1:0]     i_scan_in,
   input  wire logic [CHAINS*LEN-1:0] i_capture_data,
   output logic      [CHAINS-1:0]     o_scan_out
);

   logic [LEN-1:0] chain_r [CHAINS];

   genvar c;
   generate
      for (c = 0; c < CHAINS; c++) begin : g_chain
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               chain_r[c] <= '0;
            end else if (i_enable) begin
               if (i_capture) begin
                  chain_r[c] <= i_capture_data[c*LEN +: LEN];
               end else begin
                  chain_r[c] <= {chain_r[c][LEN-2:0], i_scan_in[c]};
               end
            end
         end
         assign o_scan_out[c] = chain_r[c][LEN-1];
      end
   endgenerate

endmodule
`default_nettype wire

// >>> tb/scan_tap_chk.sv
// Concurrent checks of the scan and test access port pins.
`default_nettype none
module scan_tap_chk (
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   input  wire logic        i_full_scan_mode_n,
   input  wire logic        i_scan_select,
   input  wire logic [7:0]  i_func_sec1_grant_n,
   input  wire logic [6:0]  i_func_sec2_grant_n,
   input  wire logic [79:0] i_capture_data,
   input  wire logic [7:0]  o_sec1_grant_pin_n,
   input  wire logic [6:0]  o_sec2_grant_pin_n,
   input  wire logic [7:0]  o_func_sec1_request,
   input  wire logic [6:0]  o_func_sec2_request_n,
   input  wire logic        o_full_scan_active,
   input  wire logic        i_tck,
   input  wire logic        i_tms,
   input  wire logic        i_trst_n,
   input  wire logic        o_tdo,
   input  wire logic        o_tdo_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------
   // Helper logic
   // ----------------
   // Capture is judged only once the select synchroniser has drained.
   logic [3:0] cap_cnt_r;
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || !(o_full_scan_active && i_scan_select &&
                         $stable(i_capture_data))) begin
         cap_cnt_r <= 4'h0;
      end else if (cap_cnt_r != 4'hF) begin
         cap_cnt_r <= cap_cnt_r + 4'h1;
      end
   end
   sequence s_mode_on;
      $fell(i_full_scan_mode_n) ##1 !i_full_scan_mode_n [*5];
   endsequence
   sequence s_mode_off;
      $rose(i_full_scan_mode_n) ##1 i_full_scan_mode_n [*5];
   endsequence
   // ----------------
   // Assertions
   // ----------------
   idle_after_reset_a: assert property (@(posedge i_clock)
      disable iff (i_sys_rst) $past(i_sys_rst) |-> !o_full_scan_active &&
      o_sec1_grant_pin_n == 8'hFF && o_sec2_grant_pin_n == 7'h7F)
      else $error("grant pins not idle after reset");
   grant_follow_a: assert property (@(posedge i_clock)
      disable iff (i_sys_rst) !o_full_scan_active &&
      !$past(o_full_scan_active) && !$past(i_sys_rst) |->
      o_sec1_grant_pin_n == $past(i_func_sec1_grant_n) &&
      o_sec2_grant_pin_n == $past(i_func_sec2_grant_n))
      else $error("grant pins do not follow arbiter");
   edge_bits_a: assert property (@(posedge i_clock)
      disable iff (i_sys_rst) o_full_scan_active &&
      $past(o_full_scan_active) |->
      (o_sec1_grant_pin_n & 8'h83) == ($past(i_func_sec1_grant_n) & 8'h83)
      && (o_sec2_grant_pin_n & 7'h03) == ($past(i_func_sec2_grant_n) & 7'h03))
      else $error("unscanned grant bits lost in scan mode");
   req_idle_a: assert property (@(posedge i_clock)
      disable iff (i_sys_rst) o_full_scan_active && $past(o_full_scan_active)
      |-> o_func_sec1_request == 8'hFF && o_func_sec2_request_n == 7'h7F)
      else $error("requests reach arbiter in scan mode");
   mode_on_a: assert property (@(posedge i_clock)
      disable iff (i_sys_rst) s_mode_on |-> o_full_scan_active)
      else $error("scan mode not entered");
   mode_off_a: assert property (@(posedge i_clock)
      disable iff (i_sys_rst) s_mode_off |-> !o_full_scan_active)
      else $error("scan mode not left");
   cap_parallel_a: assert property (@(posedge i_clock)
      disable iff (i_sys_rst) cap_cnt_r >= 4'h7 |->
      o_sec1_grant_pin_n[6:2] == {i_capture_data[39], i_capture_data[31],
      i_capture_data[23], i_capture_data[15], i_capture_data[7]} &&
      o_sec2_grant_pin_n[6:2] == {i_capture_data[79], i_capture_data[71],
      i_capture_data[63], i_capture_data[55], i_capture_data[47]})
      else $error("capture data not on grant pins");
   tms_reset_a: assert property (@(posedge i_tck)
      disable iff (!i_trst_n) i_tms [*5] |=> !o_tdo_oe)
      else $error("five high mode bits did not reset the port");
   trst_idle_a: assert property (@(posedge i_clock)
      disable iff (i_sys_rst) !i_trst_n [*2] |-> !o_tdo_oe && !o_tdo)
      else $error("serial output active under test reset");
   tdo_gate_a: assert property (@(posedge i_tck)
      disable iff (!i_trst_n) !i_scan_select [*6] |-> !o_tdo_oe)
      else $error("serial output driven with select low");
endmodule
bind scan_tap_top scan_tap_chk u_chk (
   .i_clock               (i_clock),
   .i_sys_rst             (i_sys_rst),
   .i_full_scan_mode_n    (i_full_scan_mode_n),
   .i_scan_select         (i_scan_select),
   .i_func_sec1_grant_n   (i_func_sec1_grant_n),
   .i_func_sec2_grant_n   (i_func_sec2_grant_n),
   .i_capture_data        (i_capture_data),
   .o_sec1_grant_pin_n    (o_sec1_grant_pin_n),
   .o_sec2_grant_pin_n    (o_sec2_grant_pin_n),
   .o_func_sec1_request   (o_func_sec1_request),
   .o_func_sec2_request_n (o_func_sec2_request_n),
   .o_full_scan_active    (o_full_scan_active),
   .i_tck                 (i_tck),
   .i_tms                 (i_tms),
   .i_trst_n              (i_trst_n),
   .o_tdo                 (o_tdo),
   .o_tdo_oe              (o_tdo_oe)
);
`default_nettype wire

// >>> tb/tap_tester.sv
// Boundary-scan controller model driving the test access port pins.
`default_nettype none
module tap_tester (
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   output logic      o_trst_n,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pull-ups hold TMS and TDI high; test reset starts low; the clock stands low between frames.
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
      o_trst_n = 1'b0;
   end
   task automatic test_reset();
      o_trst_n = 1'b0;
      #200;
      o_trst_n = 1'b1;
   endtask
   task automatic step(input logic tms, input logic tdi,
                       output logic tdo, output logic oe);
      o_tms = tms;
      o_tdi = tdi;
      #23;
      tdo = i_tdo;
      oe = i_tdo_oe;
      o_tck = 1'b1;
      #24;
      o_tck = 1'b0;
      #1;
   endtask
   task automatic idle();
      o_tms = 1'b1;
      o_tdi = 1'b1;
      #1;
   endtask
   task automatic move(input logic [7:0] seq, input int n);
      logic t;
      logic o;
      for (int i = 0; i < n; i++) step(seq[i], 1'b1, t, o);
   endtask
   // data goes least significant bit first
   task automatic shift(input int n, input logic [31:0] din,
                        output logic [31:0] dout, output int cnt);
      logic t;
      logic o;
      dout = 32'h0;
      cnt = 0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], t, o);
         dout[i] = t;
         cnt += int'(o);
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/scan_tap_top_bench.sv
// Self-checking bench for the scan and test access port logic.
`default_nettype none
module scan_tap_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // Arbitrary identification value.
   localparam logic [31:0] ID = 32'h0F0F_3C5A;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        mode_n = 1'b1;
   logic        sel = 1'b0;
   logic [7:0]  req1 = 8'hFF;
   logic [6:0]  req2 = 7'h7F;
   logic [7:0]  fg1 = 8'hFF;
   logic [6:0]  fg2 = 7'h7F;
   logic [79:0] cap = 80'h0;
   logic [7:0]  g1, fr1;
   logic [6:0]  g2, fr2;
   logic        active, tdo, tdo_oe, tck, tms, tdi, trst_n;
   logic [31:0] din, dout, irout;
   logic [23:0] st [10];
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          seed = 46;
   int          oe_cnt;
   scan_tap_top #(.ID_VALUE(ID)) u_dut (
      .i_clock(clock), .i_sys_rst(rst), .i_full_scan_mode_n(mode_n),
      .i_scan_select(sel), .i_sec1_request_pin(req1),
      .i_sec2_request_pin_n(req2), .i_func_sec1_grant_n(fg1),
      .i_func_sec2_grant_n(fg2), .i_capture_data(cap),
      .o_sec1_grant_pin_n(g1), .o_sec2_grant_pin_n(g2),
      .o_func_sec1_request(fr1), .o_func_sec2_request_n(fr2),
      .o_full_scan_active(active), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe)
   );
   tap_tester u_tap (
      .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
      .i_tdo(tdo), .i_tdo_oe(tdo_oe)
   );
   always #25 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (fail_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   // Instruction scan, then a data scan of n bits from idle back to idle.
   task automatic tap_scan(input logic [3:0] ir, input int n);
      int c;
      u_tap.move(8'h03, 4);
      u_tap.shift(4, {28'h0, ir}, irout, c);
      u_tap.move(8'h03, 4);
      u_tap.shift(n, din, dout, oe_cnt);
      u_tap.move(8'h01, 2);
      u_tap.idle();
   endtask
   initial begin
      cyc(6);
      rst = 1'b0;
      check({g1, g2, fr1, fr2, active}, {8'hFF, 7'h7F, 8'hFF, 7'h7F, 1'b0});
      check({tdo, tdo_oe}, 2'b00);
      // functional use keeps mode high and select low
      repeat (8) begin
         {req1, req2, fg1, fg2} = 30'($random(seed));
         cyc(6);
         check({g1, g2, fr1, fr2, active}, {fg1, fg2, req1, req2, 1'b0});
      end
      mode_n = 1'b0;
      req1 = 8'h00;
      req2 = 7'h00;
      cyc(6);
      check({active, fr1, fr2}, {1'b1, 8'hFF, 7'h7F});
      {fg1, fg2} = 15'($random(seed));
      cyc(20);
      check({g1 & 8'h83, g2 & 7'h03}, {fg1 & 8'h83, fg2 & 7'h03});
      check({g1[6:2], g2[6:2]}, 10'h000);
      req1 = 8'hFF;
      req2 = 7'h7F;
      cyc(10);
      check({g1[6:2], g2[6:2]}, 10'h000);
      cyc(4);
      check({g1[6:2], g2[6:2]}, 10'h3FF);
      req1 = 8'h00;
      req2 = 7'h00;
      cap = {16'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      sel = 1'b1;
      cyc(9);
      sel = 1'b0;
      for (int k = 0; k < 24; k++) begin
         cyc(1);
         for (int c = 0; c < 10; c++)
            st[c] = {st[c][22:0], c < 5 ? g1[c + 2] : g2[c - 3]};
      end
      // The captured byte leaves the tail MSB first from the fifth sample.
      for (int c = 0; c < 10; c++)
         check(st[c][12 +: 8], cap[c * 8 +: 8]);
      mode_n = 1'b1;
      {fg1, fg2} = 15'($random(seed));
      cyc(6);
      check({active, g1, g2, fr1, fr2}, {1'b0, fg1, fg2, req1, req2});
      sel = 1'b1;
      u_tap.test_reset();
      u_tap.move(8'h1F, 6);
      din = $random(seed);
      tap_scan(scan_tap_pkg::IR_IDCODE, 32);
      check(irout[3:0], scan_tap_pkg::IR_CAPTURE);
      check({oe_cnt[7:0], dout}, {8'h20, ID});
      tap_scan(scan_tap_pkg::IR_STATUS, 8);
      check(dout[7:0] & 8'hF7, 8'h05);
      tap_scan(scan_tap_pkg::IR_BYPASS, 8);
      check(dout[7:0], {din[6:0], 1'b0});
      cyc(1);
      sel = 1'b0;
      tap_scan(scan_tap_pkg::IR_IDCODE, 32);
      check(oe_cnt[7:0], 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
